// [isp_mst.sv]
// Behavioural bus master model driving the two-wire pins
`timescale 1ns/1ns
module isp_mst (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end
    // One clock pulse: data set while SCL low, sampled at the end of high, just before SCL is pulled low
    task automatic bit_cyc(input logic b, output logic s);
        o_sda_oe = ~b;
        #100 o_scl_oe = 1'b0;
        wait (i_scl === 1'b1);
        #100 s = i_sda;
        o_scl_oe = 1'b1;
    endtask
    task automatic start();
        o_sda_oe = 1'b0;
        #100 o_scl_oe = 1'b0;
        #100 o_sda_oe = 1'b1;
        #100 o_scl_oe = 1'b1;
        #50;
    endtask
    task automatic stop();
        o_sda_oe = 1'b1;
        #100 o_scl_oe = 1'b0;
        #100 o_sda_oe = 1'b0;
        #100;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ma,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], r[i]);
        bit_cyc(ma, a);
    endtask
endmodule

// [isp_pkg.sv]
// Package for the two-wire slave port: modes, states and carriers
package isp_pkg;

    localparam logic [3:0] ISP_MODE_SLV7 = 4'h6;
    localparam logic [3:0] ISP_MODE_SLV10 = 4'h7;
    localparam logic [3:0] ISP_MODE_SLV7_SS = 4'hB;
    localparam logic [3:0] ISP_MODE_SLV10_SS = 4'hF;
    localparam logic [3:0] ISP_MODE_MASTER_SS = 4'hE;

    localparam logic [4:0] ISP_TEN_BIT_HDR = 5'h1E;
    localparam logic [3:0] ISP_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ISP_LAST_TX_BIT = 4'h7;
    localparam logic [3:0] ISP_CNT_RST = 4'h0;
    localparam logic [7:0] ISP_BYTE_RST = 8'h00;

    localparam logic [1:0] ISP_PH_ADDR1 = 2'h0;
    localparam logic [1:0] ISP_PH_ADDR2 = 2'h1;
    localparam logic [1:0] ISP_PH_DATA = 2'h2;

    typedef enum logic [6:0] {
        L_IDLE = 7'h01,
        L_RECV = 7'h02,
        L_ACK = 7'h04,
        L_HOLD = 7'h08,
        L_SEND = 7'h10,
        L_MACK = 7'h20,
        L_SKIP = 7'h40
    } isp_lstate_type;

    // Static configuration passed from core to link
    typedef struct packed {
        logic en;
        logic slave_on;
        logic ten;
        logic scl_dir;
        logic sda_dir;
    } isp_cfg_type;

    // Byte event payload, held stable while its toggle crosses
    typedef struct packed {
        logic [7:0] data;
        logic load;
        logic is_data;
        logic ua;
        logic rw;
        logic rw_valid;
        logic tx_hold;
        logic done;
    } isp_evt_type;

    // Pins and core levels the link domain samples through two flip-flops; addr and buf_q are read directly
    typedef struct packed {
        logic scl;
        logic sda;
        logic rst;
        isp_cfg_type cfg;
        logic bf;
        logic ovf;
        logic addr_t;
        logic rel_t;
        logic txl_t;
    } isp_lsync_type;

    // Link toggles sampled by the core domain
    typedef struct packed {
        logic evt_t;
        logic sta_t;
        logic sto_t;
    } isp_csync_type;

    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        isp_lstate_type st;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic [7:0] tx_sr;
        logic [7:0] addr_l;
        logic [1:0] phase;
        logic ack;
        logic hit;
        logic tx;
        logic hold_pend;
        logic hold_tx;
        logic matched10;
        logic addr_seen;
        logic rel_seen;
        logic txl_seen;
        isp_evt_type evt;
        logic evt_t;
        logic sta_t;
        logic sto_t;
    } isp_link_type;

    typedef struct packed {
        logic [7:0] buf_q;
        logic [7:0] addr;
        isp_cfg_type cfg;
        logic ss_int;
        logic bf;
        logic ovf;
        logic irq;
        logic ua;
        logic rw;
        logic clock_release_bit;
        logic s_seen;
        logic p_seen;
        logic addr_t;
        logic rel_t;
        logic txl_t;
        isp_csync_type seen;
    } isp_core_type;

endpackage

// [isp_slave_port.sv]
// Two-wire slave port: core-side status and link-side bus engine
// How it works
// [RL1] Slave with 7-bit and 10-bit addressing; no general call decode.
// [RL2] Four-bit mode picks one of five modes, three with start/stop interrupts.
// [RL3] Mode 0110 is 7-bit slave, 0111 is 10-bit slave.
// [RL4] Nothing operates unless the port enable input is high; a start or stop still sets the flag when mode bit 3 is set.
// [RL5] Pins are driven open-drain only when their direction bit says input.
// [RL6] As transmitter the port drives SDA with its own data.
// [RL7] After a start, eight bits are shifted in on rising SCL.
// [RL8] On the eighth falling SCL, shift bits 7..1 meet the own address.
// [RL9] Match with buffer free: load buffer, set full, acknowledge, flag.
// [RL10] Buffer full or overflow: no acknowledge, no load, flag still set.
// [RL11] Reading the buffer clears full; software clears overflow.
// [RL12] Master sends 11110, two high bits, write bit for 10-bit.
// [RL13] First 10-bit byte sets flag, full, update; SCL held until write.
// [RL14] Second 10-bit byte sets flag, full, update again; rewrite clears.
// [RL15] High byte after repeated start sets flag and full, not update.
// [RL16] Matched write address clears direction bit, loads buffer.
// [RL17] Matched read address sets direction bit, loads buffer.
// [RL18] Flag rises once per byte; software clears it.
// [RL19] Transmitter acks, holds SCL low until software releases it.
// [RL20] Master samples SCL before each clock; slave may stretch.
// [RL21] Transmit bits change on falling SCL only.
// [RL22] Master acknowledge latched on the ninth rising SCL.
// [RL23] Master not acknowledging ends transfer and resets status.
// [RL24] After master ack, software loads data and releases clock.
// [RL25] Start/stop seen bits clear on reset or disable, follow conditions.
// [RL26] Address mismatch: no ack, ignore bus until next start.
// [RL27] SCL and SDA synchronised; start and stop found while SCL high.
`timescale 1ns/1ns
module isp_slave_port
    import isp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_enable,
    input wire logic [3:0] i_mode,
    input wire logic i_scl_dir,
    input wire logic i_sda_dir,
    input wire logic i_addr_wr,
    input wire logic [7:0] i_addr_wdata,
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic i_buf_rd,
    input wire logic i_ovf_clr,
    input wire logic i_irq_clr,
    input wire logic i_ckp_set,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic [7:0] o_buf_rdata,
    output logic [7:0] o_own_addr,
    output logic o_buffer_full,
    output logic o_overflow,
    output logic o_irq_flag,
    output logic o_addr_update,
    output logic o_read_dir,
    output logic o_clock_release,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_scl_o,
    output logic o_scl_oe,
    output logic o_sda_o,
    output logic o_sda_oe
);

    isp_core_type cq_reg, cq_next;
    isp_link_type lq_reg, lq_next;
    isp_csync_type c_s1, c_s2;
    isp_lsync_type l_s1, l_s2, l_raw;
    isp_evt_type ev;
    logic evt_p, sta_p, sto_p, i2c_mode;
    logic l_rst, l_rise, l_fall, l_start, l_stop;
    logic l_ok, l_hdr, l_addr_chg, l_rel_chg, l_txl_chg;

    // Core domain: sync link toggles, decode events
    always_ff @(posedge i_core_clk) begin
        c_s1 <= {lq_reg.evt_t, lq_reg.sta_t, lq_reg.sto_t};
        c_s2 <= c_s1;
    end

    assign ev = lq_reg.evt;
    assign evt_p = c_s2.evt_t != cq_reg.seen.evt_t;
    assign sta_p = c_s2.sta_t != cq_reg.seen.sta_t;
    assign sto_p = c_s2.sto_t != cq_reg.seen.sto_t;
    assign i2c_mode = i_mode == ISP_MODE_SLV7 || i_mode == ISP_MODE_SLV10
        || i_mode == ISP_MODE_SLV7_SS || i_mode == ISP_MODE_SLV10_SS
        || i_mode == ISP_MODE_MASTER_SS;

    always_comb begin
        cq_next = cq_reg;
        cq_next.seen = c_s2;
        cq_next.cfg.en = i_enable && i2c_mode; // RL4
        cq_next.cfg.slave_on = i_mode != ISP_MODE_MASTER_SS; // RL2
        cq_next.cfg.ten = i_mode[0]; // RL3
        cq_next.ss_int = i_mode[3]; // RL2
        cq_next.cfg.scl_dir = i_scl_dir;
        cq_next.cfg.sda_dir = i_sda_dir;
        if (i_addr_wr) begin
            cq_next.addr = i_addr_wdata;
            cq_next.addr_t = ~cq_reg.addr_t;
            cq_next.ua = 1'b0; // RL13 RL14
        end
        if (i_buf_wr) begin
            cq_next.buf_q = i_buf_wdata;
            cq_next.txl_t = ~cq_reg.txl_t; // RL19
        end
        if (i_buf_rd) begin
            cq_next.bf = 1'b0; // RL11
        end
        if (i_ovf_clr) begin
            cq_next.ovf = 1'b0; // RL11
        end
        if (i_irq_clr) begin
            cq_next.irq = 1'b0; // RL18
        end
        if (i_ckp_set) begin
            cq_next.clock_release_bit = 1'b1;
            cq_next.rel_t = ~cq_reg.rel_t; // RL24
        end
        if (evt_p && ev.done) begin
            cq_next.rw = 1'b0; // RL23
            cq_next.ua = 1'b0;
            cq_next.bf = 1'b0;
        end else if (evt_p) begin
            cq_next.irq = 1'b1; // RL18
            if (ev.load) begin
                cq_next.buf_q = ev.data; // RL9
                cq_next.bf = 1'b1;
            end else if (ev.is_data && cq_reg.bf) begin
                cq_next.ovf = 1'b1; // RL10
            end
            if (ev.ua) begin
                cq_next.ua = 1'b1; // RL13 RL14
            end
            if (ev.rw_valid) begin
                cq_next.rw = ev.rw; // RL16 RL17
            end
            if (ev.tx_hold) begin
                cq_next.clock_release_bit = 1'b0; // RL19
            end
        end
        if (sta_p) begin
            cq_next.s_seen = 1'b1; // RL25
            cq_next.p_seen = 1'b0;
            cq_next.irq = cq_next.irq || cq_reg.ss_int;
        end
        if (sto_p) begin
            cq_next.p_seen = 1'b1; // RL25
            cq_next.s_seen = 1'b0;
            cq_next.irq = cq_next.irq || cq_reg.ss_int;
        end
        if (!i_enable) begin
            cq_next.s_seen = 1'b0; // RL25
            cq_next.p_seen = 1'b0;
        end
        if (i_srst) begin
            cq_next = '0;
            cq_next.seen = c_s2;
        end
    end

    always_ff @(posedge i_core_clk) begin
        cq_reg <= cq_next;
    end

    assign o_buf_rdata = cq_reg.buf_q;
    assign o_own_addr = cq_reg.addr;
    assign o_buffer_full = cq_reg.bf;
    assign o_overflow = cq_reg.ovf;
    assign o_irq_flag = cq_reg.irq;
    assign o_addr_update = cq_reg.ua;
    assign o_read_dir = cq_reg.rw;
    assign o_clock_release = cq_reg.clock_release_bit;
    assign o_start_seen = cq_reg.s_seen;
    assign o_stop_seen = cq_reg.p_seen;

    // Link domain: two-stage sync of pins and core levels
    assign l_raw = {i_scl, i_sda, i_srst, cq_reg.cfg, cq_reg.bf,
        cq_reg.ovf, cq_reg.addr_t, cq_reg.rel_t, cq_reg.txl_t};

    always_ff @(posedge i_link_clk) begin
        l_s1 <= l_raw; // RL27
        l_s2 <= l_s1;
    end

    assign l_rst = l_s2.rst;
    assign l_rise = l_s2.scl && !lq_reg.scl_prev;
    assign l_fall = !l_s2.scl && lq_reg.scl_prev;
    assign l_start = l_s2.scl && lq_reg.scl_prev && lq_reg.sda_prev
        && !l_s2.sda; // RL27
    assign l_stop = l_s2.scl && lq_reg.scl_prev && !lq_reg.sda_prev
        && l_s2.sda; // RL27
    assign l_ok = !l_s2.bf && !l_s2.ovf; // RL10
    assign l_hdr = lq_reg.sr[7:3] == ISP_TEN_BIT_HDR
        && lq_reg.sr[2:1] == lq_reg.addr_l[2:1]; // RL12
    assign l_addr_chg = l_s2.addr_t != lq_reg.addr_seen;
    assign l_rel_chg = l_s2.rel_t != lq_reg.rel_seen;
    assign l_txl_chg = l_s2.txl_t != lq_reg.txl_seen;

    always_comb begin
        lq_next = lq_reg;
        lq_next.scl_prev = l_s2.scl;
        lq_next.sda_prev = l_s2.sda;
        lq_next.addr_seen = l_s2.addr_t;
        lq_next.rel_seen = l_s2.rel_t;
        lq_next.txl_seen = l_s2.txl_t;
        if (l_addr_chg) begin
            lq_next.addr_l = cq_reg.addr;
        end
        if (l_txl_chg) begin
            lq_next.tx_sr = cq_reg.buf_q; // RL19
        end
        unique case (lq_reg.st)
            L_IDLE, L_SKIP: begin
                lq_next.cnt = ISP_CNT_RST; // RL26
            end
            L_RECV: begin
                if (l_rise) begin
                    lq_next.sr = {lq_reg.sr[6:0], l_s2.sda}; // RL7
                    lq_next.cnt = lq_reg.cnt + 4'h1;
                end
                if (l_fall && lq_reg.cnt == ISP_BITS_PER_BYTE) begin
                    lq_next.st = L_ACK;
                    lq_next.ack = 1'b0;
                    lq_next.hit = 1'b0;
                    lq_next.hold_pend = 1'b0;
                    lq_next.evt = '0;
                    lq_next.evt.data = lq_reg.sr;
                    if (lq_reg.phase == ISP_PH_DATA) begin
                        lq_next.hit = 1'b1;
                        lq_next.ack = l_ok; // RL10
                        lq_next.evt.load = l_ok;
                        lq_next.evt.is_data = 1'b1;
                    end else if (lq_reg.phase == ISP_PH_ADDR2) begin
                        if (lq_reg.sr == lq_reg.addr_l) begin // RL14
                            lq_next.hit = 1'b1;
                            lq_next.ack = l_ok;
                            lq_next.evt.load = l_ok;
                            lq_next.evt.ua = l_ok;
                            lq_next.evt.rw_valid = l_ok; // RL16
                            lq_next.hold_pend = l_ok;
                            lq_next.matched10 = l_ok;
                            if (l_ok) begin
                                lq_next.phase = ISP_PH_DATA;
                            end
                        end
                    end else if (l_s2.cfg.ten) begin // RL1
                        if (l_hdr && !lq_reg.sr[0]) begin
                            lq_next.hit = 1'b1; // RL13
                            lq_next.ack = l_ok;
                            lq_next.evt.load = l_ok;
                            lq_next.evt.ua = l_ok;
                            lq_next.hold_pend = l_ok;
                            lq_next.matched10 = 1'b0;
                            if (l_ok) begin
                                lq_next.phase = ISP_PH_ADDR2;
                            end
                        end else if (l_hdr && lq_reg.matched10) begin
                            lq_next.hit = 1'b1; // RL15
                            lq_next.ack = l_ok;
                            lq_next.evt.load = l_ok;
                            lq_next.evt.rw_valid = l_ok;
                            lq_next.evt.rw = 1'b1; // RL17
                            lq_next.evt.tx_hold = l_ok;
                            lq_next.tx = l_ok;
                            if (l_ok) begin
                                lq_next.phase = ISP_PH_DATA;
                            end
                        end
                    end else if (lq_reg.sr[7:1] == lq_reg.addr_l[7:1]) begin
                        lq_next.hit = 1'b1; // RL8
                        lq_next.ack = l_ok; // RL9
                        lq_next.evt.load = l_ok;
                        lq_next.evt.rw_valid = l_ok;
                        lq_next.evt.rw = lq_reg.sr[0]; // RL16 RL17
                        lq_next.evt.tx_hold = l_ok && lq_reg.sr[0];
                        lq_next.tx = l_ok && lq_reg.sr[0];
                        if (l_ok) begin
                            lq_next.phase = ISP_PH_DATA;
                        end
                    end
                end
            end
            L_ACK: begin
                if (l_fall) begin
                    lq_next.cnt = ISP_CNT_RST;
                    if (lq_reg.hit) begin
                        lq_next.evt_t = ~lq_reg.evt_t; // RL9 RL18
                    end
                    if (!lq_reg.ack) begin
                        lq_next.st = (lq_reg.phase == ISP_PH_DATA
                            && !lq_reg.tx) ? L_RECV : L_SKIP; // RL26
                    end else if (lq_reg.hold_pend) begin
                        lq_next.st = L_HOLD; // RL13
                        lq_next.hold_tx = 1'b0;
                    end else if (lq_reg.tx) begin
                        lq_next.st = L_HOLD; // RL19
                        lq_next.hold_tx = 1'b1;
                    end else begin
                        lq_next.st = L_RECV;
                    end
                end
            end
            L_HOLD: begin
                lq_next.cnt = ISP_CNT_RST;
                if (lq_reg.hold_tx && l_rel_chg) begin
                    lq_next.st = L_SEND; // RL20 RL24
                end else if (!lq_reg.hold_tx && l_addr_chg) begin
                    lq_next.st = L_RECV; // RL13 RL14
                end
            end
            L_SEND: begin
                if (l_fall && lq_reg.cnt == ISP_LAST_TX_BIT) begin
                    lq_next.st = L_MACK;
                end else if (l_fall) begin
                    lq_next.tx_sr = {lq_reg.tx_sr[6:0], 1'b0}; // RL21
                    lq_next.cnt = lq_reg.cnt + 4'h1;
                end
            end
            L_MACK: begin
                if (l_rise) begin
                    lq_next.ack = !l_s2.sda; // RL22
                end
                if (l_fall) begin
                    lq_next.evt = '0;
                    lq_next.evt_t = ~lq_reg.evt_t;
                    if (lq_reg.ack) begin
                        lq_next.st = L_HOLD; // RL19
                        lq_next.hold_tx = 1'b1;
                        lq_next.evt.tx_hold = 1'b1;
                    end else begin
                        lq_next.st = L_IDLE; // RL23
                        lq_next.evt.done = 1'b1;
                        lq_next.phase = ISP_PH_ADDR1;
                        lq_next.tx = 1'b0;
                    end
                end
            end
            default: begin
                lq_next.st = L_IDLE;
            end
        endcase
        if (l_start) begin
            lq_next.sta_t = ~lq_reg.sta_t; // RL25
            lq_next.st = l_s2.cfg.slave_on ? L_RECV : L_IDLE; // RL7
            lq_next.cnt = ISP_CNT_RST;
            lq_next.sr = ISP_BYTE_RST;
            lq_next.phase = ISP_PH_ADDR1;
            lq_next.tx = 1'b0;
        end
        if (l_stop) begin
            lq_next.sto_t = ~lq_reg.sto_t; // RL25
            lq_next.st = L_IDLE;
            lq_next.matched10 = 1'b0;
        end
        if (!l_s2.cfg.en) begin
            lq_next.st = L_IDLE; // RL4
            lq_next.phase = ISP_PH_ADDR1;
            lq_next.matched10 = 1'b0;
        end
        if (l_rst) begin
            lq_next = '0;
            lq_next.st = L_IDLE;
        end
    end

    always_ff @(posedge i_link_clk) begin
        lq_reg <= lq_next;
    end

    // Open-drain pins: only ever pull low
    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe = l_s2.cfg.en && l_s2.cfg.scl_dir
        && lq_reg.st == L_HOLD; // RL5 RL19
    assign o_sda_oe = l_s2.cfg.en && l_s2.cfg.sda_dir
        && ((lq_reg.st == L_ACK && lq_reg.ack)
        || (lq_reg.st == L_SEND && !lq_reg.tx_sr[7])); // RL5 RL6

    addr_ack_a: assert property ( // RL9
        @(posedge i_link_clk) disable iff (l_rst)
        (l_fall && !l_start && !l_stop && l_s2.cfg.en && !l_s2.cfg.ten
        && lq_reg.st == L_RECV && lq_reg.cnt == ISP_BITS_PER_BYTE
        && lq_reg.phase == ISP_PH_ADDR1 && l_ok
        && lq_reg.sr[7:1] == lq_reg.addr_l[7:1])
        |=> (lq_reg.st == L_ACK && lq_reg.ack))
        else $error("matched address not acknowledged");

    full_nack_a: assert property ( // RL10
        @(posedge i_link_clk) disable iff (l_rst)
        (l_fall && lq_reg.st == L_RECV && !l_ok
        && lq_reg.cnt == ISP_BITS_PER_BYTE) |=> !lq_reg.ack)
        else $error("acknowledge given with buffer full");

    hold_scl_a: assert property ( // RL19
        @(posedge i_link_clk) disable iff (l_rst)
        (lq_reg.st == L_HOLD && lq_reg.hold_tx && !l_rel_chg && !l_start
        && !l_stop && l_s2.cfg.en) |=> lq_reg.st == L_HOLD)
        else $error("clock hold left without release");

    nack_end_a: assert property ( // RL23
        @(posedge i_link_clk) disable iff (l_rst)
        (lq_reg.st == L_MACK && l_fall && !lq_reg.ack && !l_start
        && l_s2.cfg.en) |=> (lq_reg.st == L_IDLE && lq_reg.evt.done))
        else $error("missing end of transfer after no ack");

    ack_latch_a: assert property ( // RL22
        @(posedge i_link_clk) disable iff (l_rst)
        (lq_reg.st == L_MACK && l_rise && !l_stop && l_s2.cfg.en)
        |=> lq_reg.ack == !$past(l_s2.sda))
        else $error("master acknowledge not latched");

    tx_shift_a: assert property ( // RL21
        @(posedge i_link_clk) disable iff (l_rst)
        (lq_reg.st == L_SEND && l_fall && !l_txl_chg
        && lq_reg.cnt != ISP_LAST_TX_BIT)
        |=> lq_reg.tx_sr == ($past(lq_reg.tx_sr) << 1))
        else $error("transmit bit not shifted on falling edge");

    rx_sample_a: assert property ( // RL7
        @(posedge i_link_clk) disable iff (l_rst)
        (lq_reg.st == L_RECV && l_rise && l_s2.cfg.en)
        |=> lq_reg.sr[0] == $past(l_s2.sda))
        else $error("receive bit not sampled on rising edge");

    buf_load_a: assert property ( // RL9
        @(posedge i_core_clk) disable iff (i_srst)
        (evt_p && !ev.done && ev.load) |=> (cq_reg.bf && cq_reg.irq))
        else $error("buffer full or flag not set on load");

    buf_clear_a: assert property ( // RL11
        @(posedge i_core_clk) disable iff (i_srst)
        (i_buf_rd && !evt_p) |=> !cq_reg.bf)
        else $error("buffer read did not clear full");

    ua_clear_a: assert property ( // RL13
        @(posedge i_core_clk) disable iff (i_srst)
        (i_addr_wr && !(evt_p && ev.ua)) |=> !cq_reg.ua)
        else $error("address write did not clear update");

    start_seen_a: assert property ( // RL25
        @(posedge i_core_clk) disable iff (i_srst)
        (sta_p && !sto_p && i_enable)
        |=> (cq_reg.s_seen && !cq_reg.p_seen))
        else $error("start not recorded");

    disable_a: assert property ( // RL4
        @(posedge i_core_clk) disable iff (i_srst)
        !i_enable |=> (!cq_reg.s_seen && !cq_reg.p_seen))
        else $error("status kept while disabled");

    dir_bit_a: assert property ( // RL16
        @(posedge i_core_clk) disable iff (i_srst)
        (evt_p && !ev.done && ev.rw_valid) |=> cq_reg.rw == $past(ev.rw))
        else $error("direction bit not taken from address");

endmodule

// [tb.sv]
// Self-checking bench for the two-wire slave port
`timescale 1ns/1ns
module tb;
    import isp_pkg::*;
    logic clk, lclk, rst, en, dir, awr, bwr, brd, oclr, iclr, clock_release_bit, a;
    logic [3:0] mode;
    logic [7:0] wd, r, d, rdata, oaddr;
    logic full, ovf, irq, ua, rdir, crel, ss, ps;
    logic scl_oe, sda_oe, m_scl, m_sda;
    wire scl = ~(scl_oe | m_scl);
    wire sda = ~(sda_oe | m_sda);
    int err_count, comparisons;
    isp_slave_port dut_u (.i_core_clk(clk), .i_srst(rst), .i_link_clk(lclk),
        .i_enable(en), .i_mode(mode), .i_scl_dir(dir), .i_sda_dir(dir),
        .i_addr_wr(awr), .i_addr_wdata(wd), .i_buf_wr(bwr),
        .i_buf_wdata(wd), .i_buf_rd(brd), .i_ovf_clr(oclr),
        .i_irq_clr(iclr), .i_ckp_set(clock_release_bit), .i_scl(scl), .i_sda(sda),
        .o_buf_rdata(rdata), .o_own_addr(oaddr), .o_buffer_full(full),
        .o_overflow(ovf), .o_irq_flag(irq), .o_addr_update(ua),
        .o_read_dir(rdir), .o_clock_release(crel), .o_start_seen(ss),
        .o_stop_seen(ps), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(),
        .o_sda_oe(sda_oe));
    isp_mst m_u (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl),
        .o_sda_oe(m_sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #1;
        forever #3 lclk = ~lclk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    // Strobes {addr_wr, buf_wr, buf_rd, ovf_clr, irq_clr, ckp_set}
    task automatic sw(input logic [5:0] s, input logic [7:0] v);
        @(negedge clk);
        {awr, bwr, brd, oclr, iclr, clock_release_bit} = s;
        wd = v;
        @(negedge clk);
        {awr, bwr, brd, oclr, iclr, clock_release_bit} = 6'h00;
        repeat (4) @(negedge clk);
    endtask
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        final_report();
    end
    initial begin
        {rst, en, dir, awr, bwr, brd, oclr, iclr, clock_release_bit} = 9'h1C0;
        mode = ISP_MODE_SLV7;
        wd = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        void'($urandom(32'h38f8a1c8));
        settle();
        sw(6'h20, 8'hA0);
        chk(oaddr, 8'hA0);
        m_u.start();
        m_u.xfer(8'hA0, 1'b1, r, a);
        settle();
        chk(a, 8'h00);
        chk({ss, irq, full, rdir}, 8'h0E);
        chk(rdata, 8'hA0);
        sw(6'h08, 8'h00);
        sw(6'h02, 8'h00);
        chk(full, 8'h00);
        d = 8'($urandom);
        m_u.xfer(d, 1'b1, r, a);
        settle();
        chk(a, 8'h00);
        chk(rdata, d);
        sw(6'h02, 8'h00);
        m_u.xfer(~d, 1'b1, r, a);
        settle();
        chk({a, irq, ovf}, 8'h07);
        chk(rdata, d);
        m_u.stop();
        settle();
        chk(ps, 8'h01);
        $display("test write done");
        sw(6'h0E, 8'h00);
        m_u.start();
        m_u.xfer(8'hA4, 1'b1, r, a);
        chk(a, 8'h01);
        m_u.start();
        m_u.xfer(8'hA1, 1'b1, r, a);
        settle();
        chk({a, rdir, full, crel}, 8'h06);
        d = 8'($urandom);
        fork
            m_u.xfer(8'hFF, 1'b1, r, a);
            begin
                sw(6'h0A, 8'h00);
                sw(6'h10, d);
                sw(6'h01, 8'h00);
            end
        join
        settle();
        chk(r, d);
        chk({rdir, full, ua}, 8'h00);
        m_u.stop();
        $display("test read done");
        @(negedge clk);
        mode = ISP_MODE_SLV10;
        sw(6'h20, 8'hF4);
        m_u.start();
        m_u.xfer(8'hF4, 1'b1, r, a);
        settle();
        chk({a, ua, full, rdir}, 8'h06);
        sw(6'h0A, 8'h00);
        sw(6'h20, 8'h5C);
        chk(ua, 8'h00);
        m_u.xfer(8'h5C, 1'b1, r, a);
        settle();
        chk({a, ua, full, rdir}, 8'h06);
        chk(rdata, 8'h5C);
        sw(6'h0A, 8'h00);
        sw(6'h20, 8'hF4);
        chk(ua, 8'h00);
        m_u.start();
        m_u.xfer(8'hF5, 1'b1, r, a);
        settle();
        chk({a, ua, full, rdir}, 8'h03);
        d = 8'($urandom);
        fork
            m_u.xfer(8'hFF, 1'b0, r, a);
            begin
                sw(6'h0A, 8'h00);
                sw(6'h10, d);
                sw(6'h01, 8'h00);
            end
        join
        settle();
        chk(r, d);
        chk({crel, irq, scl_oe}, 8'h03);
        dir = 1'b0;
        settle();
        chk(scl_oe, 8'h00);
        $display("test ten-bit done");
        en = 1'b0;
        settle();
        chk({ss, ps}, 8'h00);
        en = 1'b1;
        mode = 4'h0;
        m_u.start();
        m_u.xfer(8'hA0, 1'b1, r, a);
        chk(a, 8'h01);
        m_u.stop();
        $display("test mode done");
        final_report();
    end
endmodule
